// >>> design/vic_pkg.sv
// Purpose: Constants for the vectored interrupt controller.
// Assumes: One machine cycle is one REF_CLK_I cycle.
// Notes: Register map is on a 32-bit AXI4-Lite slave.
//
// What this block does
// - Take only when request, enable, global all set
// - Enable-all sets, disable-all clears global enable
// - Taking any interrupt clears global enable
// - Activating event sets its request flag
// - Flag clears only on take or skip
// - Flags set even while masked
// - Set flag holds; interrupts once unmasked
// - Fixed priority: pin, tmr1, tmr2, conv, serial
// - Vectors 0,4,6,C,E in page one
// - Enable bit blocks skip; clear enables skip
// - Enable bits in two control registers
// - Events: pin change, underflows, conv, serial
// - Take two or three cycles after conditions
// - Enable-all effective after one more instruction
// - Clear only served flag; push return
// - Save context into interrupt context store
package vic_pkg;
  localparam int          NSRC         = 5;
  // Register byte offsets.
  localparam logic [7:0]  OFS_CTRL1    = 8'h00;
  localparam logic [7:0]  OFS_CTRL2    = 8'h04;
  localparam logic [7:0]  OFS_REQ      = 8'h08;
  localparam logic [7:0]  OFS_EVS      = 8'h0C;
  localparam logic [7:0]  OFS_MASK     = 8'h10;
  localparam logic [7:0]  OFS_STATE    = 8'h14;
  // Enable bit positions inside the control registers.
  localparam int          BIT_EXT_EN   = 0;
  localparam int          BIT_TMR1_EN  = 2;
  localparam int          BIT_TMR2_EN  = 3;
  localparam int          BIT_CONV_EN  = 2;
  localparam int          BIT_SER_EN   = 3;
  // Reset values.
  localparam logic [3:0]  CTRL_RST     = 4'h0;
  localparam logic [4:0]  SRC_RST      = 5'h00;
  // Page one base and vector word offsets.
  localparam logic [9:0]  VEC_BASE     = 10'h080;
  localparam logic [9:0]  VEC_EXT      = 10'h000;
  localparam logic [9:0]  VEC_TMR1     = 10'h004;
  localparam logic [9:0]  VEC_TMR2     = 10'h006;
  localparam logic [9:0]  VEC_CONV     = 10'h00C;
  localparam logic [9:0]  VEC_SER      = 10'h00E;
  // Entry delay in machine cycles.
  localparam logic [1:0]  DLY_SHORT    = 2'h2;
  localparam logic [1:0]  DLY_LONG     = 2'h3;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  typedef enum logic {VIC_IDLE, VIC_WAIT} vic_state_e;
endpackage : vic_pkg

// >>> design/vic_top.sv
// Purpose: Vectored interrupt controller with AXI4-Lite registers.
// Assumes: Sequencer pulses are one cycle and synchronous.
// Notes: Context save and return push are pulses with the take.
`timescale 1ns/1ps
`default_nettype none
module vic_top
  import vic_pkg::*;
(
  // Clock and reset.
  input  wire logic        REF_CLK_I,
  input  wire logic        RESETN_I,
  // Sequencer side.
  input  wire logic        ENABLE_ALL_OP_I,
  input  wire logic        DISABLE_ALL_OP_I,
  input  wire logic        INSTR_DONE_I,
  input  wire logic        MULTI_CYCLE_I,
  input  wire logic        SKIP_REQ_I,
  input  wire logic [2:0]  SKIP_SEL_I,
  output logic             SKIP_O,
  output logic             TAKE_O,
  output logic             PUSH_RET_O,
  output logic             CTX_SAVE_O,
  output logic [9:0]       VECTOR_O,
  output logic             GLOBAL_IRQ_ENABLE_O,
  // Event sources.
  input  wire logic        EXT_PIN_I,
  input  wire logic        TMR1_UFL_I,
  input  wire logic        TMR2_UFL_I,
  input  wire logic        CONV_DONE_I,
  input  wire logic        SERIAL_DONE_I,
  // AXI4-Lite slave.
  input  wire logic [7:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [7:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  // Interrupt to the system.
  output logic             IRQ_O
);
  // ------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------
  // Lowest index wins, so source 0 has the top priority.
  function automatic logic [4:0] prio1h(input logic [4:0] v);
    prio1h = v & (~v + 5'h01);
  endfunction : prio1h

  function automatic logic [9:0] vec_of(input logic [4:0] oh);
    case (oh)
      5'h01:   vec_of = VEC_BASE + VEC_EXT;
      5'h02:   vec_of = VEC_BASE + VEC_TMR1;
      5'h04:   vec_of = VEC_BASE + VEC_TMR2;
      5'h08:   vec_of = VEC_BASE + VEC_CONV;
      default: vec_of = VEC_BASE + VEC_SER;
    endcase
  endfunction : vec_of

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [3:0]  ctrl1_r;
  logic [3:0]  ctrl2_r;
  logic [4:0]  req_r;
  logic [4:0]  req_nxt;
  logic [4:0]  evs_r;
  logic [4:0]  mask_r;
  logic        gie_r;
  logic        en_pend_r;
  logic        ext_d_r;
  logic        ext_vld_r;
  logic [1:0]  cnt_r;
  vic_state_e  st_r;
  logic        take_r;
  logic [9:0]  vec_r;
  logic [4:0]  set_vec;
  logic [4:0]  en_vec;
  logic [4:0]  cond;
  logic [4:0]  take1h;
  logic [4:0]  skip1h;
  logic [4:0]  clr_vec;
  logic        take_now;
  logic        aw_h_r;
  logic        w_h_r;
  logic [7:0]  awa_r;
  logic [31:0] wd_r;
  logic [3:0]  ws_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        wr_go;
  logic [4:0]  w1c;

  // ------------------------------------------------------------
  // Sources and request flags
  // ------------------------------------------------------------
  // event sources
  // The pin is compared only after a first sample, so reset is no edge.
  assign set_vec = {SERIAL_DONE_I, CONV_DONE_I, TMR2_UFL_I, TMR1_UFL_I,
                    ext_vld_r & (EXT_PIN_I ^ ext_d_r)};

  // Previous pin level for change detection.
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ext_d_r   <= 1'b0;
      ext_vld_r <= 1'b0;
    end else begin
      ext_d_r   <= EXT_PIN_I;
      ext_vld_r <= 1'b1;
    end
  end

  assign en_vec = {ctrl2_r[BIT_SER_EN], ctrl2_r[BIT_CONV_EN],
                   ctrl1_r[BIT_TMR2_EN], ctrl1_r[BIT_TMR1_EN], ctrl1_r[BIT_EXT_EN]};
  assign cond   = req_r & en_vec & {NSRC{gie_r}};
  assign take1h = prio1h(cond);
  assign skip1h = (SKIP_REQ_I && SKIP_SEL_I < 3'h5) ?
                  (5'h01 << SKIP_SEL_I) & req_r & ~en_vec : 5'h00;
  assign SKIP_O = |skip1h;
  assign clr_vec = (take_now ? take1h : 5'h00) | skip1h;
  assign req_nxt = set_vec | (req_r & ~clr_vec);

  // Request flags.
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      req_r <= SRC_RST;
    end else begin
      req_r <= req_nxt;
    end
  end

  // ------------------------------------------------------------
  // Global enable and entry sequence
  // ------------------------------------------------------------
  // enable flag control
  // Disable wins over a pending enable so a critical section stays closed.
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      gie_r     <= 1'b0;
      en_pend_r <= 1'b0;
    end else if (DISABLE_ALL_OP_I || take_now) begin
      gie_r     <= 1'b0;
      en_pend_r <= 1'b0;
    end else if (ENABLE_ALL_OP_I) begin
      en_pend_r <= 1'b1;
    end else if (en_pend_r && INSTR_DONE_I) begin
      gie_r     <= 1'b1;
      en_pend_r <= 1'b0;
    end
  end

  assign take_now = (st_r == VIC_WAIT) && (cnt_r == 2'h1) && (|cond);
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_r  <= VIC_IDLE;
      cnt_r <= 2'h0;
    end else begin
      case (st_r)
        VIC_IDLE: begin
          if (|cond) begin
            st_r  <= VIC_WAIT;
            cnt_r <= (MULTI_CYCLE_I ? DLY_LONG : DLY_SHORT) - 2'h1;
          end
        end
        VIC_WAIT: begin
          cnt_r <= cnt_r - 2'h1;
          if (!(|cond) || cnt_r == 2'h1) begin
            st_r <= VIC_IDLE;
          end
        end
        default: st_r <= VIC_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      take_r <= 1'b0;
      vec_r  <= VEC_BASE;
    end else begin
      take_r <= take_now;
      if (take_now) begin
        vec_r <= vec_of(take1h);
      end
    end
  end
  assign TAKE_O              = take_r;
  assign PUSH_RET_O          = take_r;
  assign CTX_SAVE_O          = take_r;
  assign VECTOR_O            = vec_r;
  assign GLOBAL_IRQ_ENABLE_O = gie_r;

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  // Address and data are caught separately, in either order.
  assign AWREADY_O = !aw_h_r;
  assign WREADY_O  = !w_h_r;
  assign wr_go     = aw_h_r && w_h_r && !bvalid_r;
  assign w1c       = (wr_go && awa_r == OFS_EVS && ws_r[0]) ? wd_r[4:0] : 5'h00;
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      aw_h_r   <= 1'b0;
      w_h_r    <= 1'b0;
      awa_r    <= 8'h00;
      wd_r     <= 32'h0000_0000;
      ws_r     <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else begin
      if (AWVALID_I && !aw_h_r) begin
        aw_h_r <= 1'b1;
        awa_r  <= AWADDR_I;
      end
      if (WVALID_I && !w_h_r) begin
        w_h_r <= 1'b1;
        wd_r  <= WDATA_I;
        ws_r  <= WSTRB_I;
      end
      if (wr_go) begin
        aw_h_r   <= 1'b0;
        w_h_r    <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= (awa_r > OFS_STATE || awa_r[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_r && BREADY_I) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign BVALID_O = bvalid_r;
  assign BRESP_O  = bresp_r;

  // Writable registers; all fields live in byte lane 0.
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ctrl1_r <= CTRL_RST;
      ctrl2_r <= CTRL_RST;
      mask_r  <= SRC_RST;
    end else if (wr_go && ws_r[0]) begin
      if (awa_r == OFS_CTRL1) ctrl1_r <= wd_r[3:0];
      if (awa_r == OFS_CTRL2) ctrl2_r <= wd_r[3:0];
      if (awa_r == OFS_MASK)  mask_r  <= wd_r[4:0];
    end
  end

  // Sticky event status; a new event beats a write-one clear.
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      evs_r <= SRC_RST;
    end else begin
      evs_r <= set_vec | (evs_r & ~w1c);
    end
  end
  assign IRQ_O = |(evs_r & mask_r);

  // Read channel answers one cycle after the address is taken.
  assign ARREADY_O = !rvalid_r;
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (ARVALID_I && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      case (ARADDR_I)
        OFS_CTRL1: rdata_r <= {28'h000_0000, ctrl1_r};
        OFS_CTRL2: rdata_r <= {28'h000_0000, ctrl2_r};
        OFS_REQ:   rdata_r <= {27'h000_0000, req_r};
        OFS_EVS:   rdata_r <= {27'h000_0000, evs_r};
        OFS_MASK:  rdata_r <= {27'h000_0000, mask_r};
        OFS_STATE: rdata_r <= {30'h0000_0000, en_pend_r, gie_r};
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && RREADY_I) begin
      rvalid_r <= 1'b0;
    end
  end
  assign RVALID_O = rvalid_r;
  assign RDATA_O  = rdata_r;
  assign RRESP_O  = rresp_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESETN_I);

  sequence s_arm;
    st_r == VIC_IDLE && (|cond) && !MULTI_CYCLE_I && !DISABLE_ALL_OP_I;
  endsequence
  sequence s_keep;
    |cond;
  endsequence

  chk_take_gate:  assert property (take_now |-> gie_r && (take1h & req_r & en_vec) != 5'h00)
    else $error("Take without all three conditions.");
  chk_dis_clears: assert property (DISABLE_ALL_OP_I |=> !gie_r && !en_pend_r)
    else $error("Disable-all did not clear the enable.");
  chk_take_gie:   assert property (take_now |=> TAKE_O && !gie_r)
    else $error("Enable flag survived a take.");
  chk_req_set:    assert property ((set_vec != 5'h00) |=> (req_r & $past(set_vec)) == $past(set_vec))
    else $error("Event lost on a request flag.");
  chk_req_hold:   assert property (1'b1 |=> (req_r & $past(req_r & ~clr_vec)) == $past(req_r & ~clr_vec))
    else $error("Request flag dropped without a clear.");
  chk_prio_order: assert property (take_now |-> ((take1h - 5'h01) & cond) == 5'h00)
    else $error("Lower priority served first.");
  chk_vec_set:    assert property (TAKE_O |-> VECTOR_O inside {10'h080, 10'h084, 10'h086, 10'h08C, 10'h08E})
    else $error("Vector outside the table.");
  chk_short_dly:  assert property (s_arm ##1 s_keep |=> TAKE_O)
    else $error("Entry not two cycles after conditions.");
  chk_ena_late:   assert property ($rose(gie_r) |-> $past(en_pend_r) && $past(INSTR_DONE_I))
    else $error("Enable took effect too early.");
  chk_skip_mask:  assert property (SKIP_REQ_I && SKIP_SEL_I < 3'h5 && en_vec[SKIP_SEL_I] |-> !SKIP_O)
    else $error("Skip worked while source enabled.");
endmodule : vic_top
`default_nettype wire

// >>> tb/vic_partner.sv
// Purpose: Sequencer and event source model facing the interrupt controller.
// Assumes: Tasks are called just after a rising edge of clk_i.
// Notes: Pulses last one cycle; the pin and the multi-cycle flag are levels.
`timescale 1ns/1ps
`default_nettype none
module vic_partner (
  // Clock.
  input  wire logic       clk_i,
  // Sequencer outputs.
  output logic            ena_o,
  output logic            dis_o,
  output logic            done_o,
  output logic            multi_o,
  // Event sources, ev_o is serial, conv, tmr2, tmr1 from the top.
  output logic            pin_o,
  output logic [3:0]      ev_o
);
  // Quiet at time zero so that nothing is requested during reset.
  initial begin
    {ena_o, dis_o, done_o, multi_o, pin_o, ev_o} = '0;
  end
  task automatic op(input logic en, input logic off);
    ena_o <= en;
    dis_o <= off;
    @(posedge clk_i);
    ena_o <= 1'b0;
    dis_o <= 1'b0;
  endtask : op
  // retire one instruction
  // A slow core retires late; the multi level stays until the next retire.
  task automatic retire(input int gap, input logic mc);
    repeat (gap) @(posedge clk_i);
    done_o  <= 1'b1;
    multi_o <= mc;
    @(posedge clk_i);
    done_o  <= 1'b0;
  endtask : retire
  // activating events
  // The pin toggles rather than pulses, since any level change counts.
  task automatic fire(input logic [4:0] m);
    pin_o <= pin_o ^ m[0];
    ev_o  <= m[4:1];
    @(posedge clk_i);
    ev_o  <= 4'h0;
  endtask : fire
endmodule : vic_partner
`default_nettype wire

// >>> tb/vic_top_test.sv
// Purpose: Self-checking bench for the vectored interrupt controller.
// Assumes: Bus and partner tasks start just after a rising clock edge.
// Notes: Expected vectors are built from the package constants.
`timescale 1ns/1ps
`default_nettype none
module vic_top_test;
  import vic_pkg::*;
  logic             clk, rstn, skreq, awv, wv, br, arv, rr;
  logic [2:0]       sksel;
  logic [7:0]       awa, ara;
  logic [31:0]      wd, d;
  logic [3:0]       ws;
  logic [1:0]       rsp;
  wire logic        skip, take, push, ctx, gie, awrdy, wrdy, bv, arrdy, rv, irq;
  wire logic        ena, dis, done, multi, pin;
  wire logic [3:0]  ev;
  wire logic [9:0]  vec;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int               n_mismatch, num_checks, n;
  logic [9:0]       vt [5] = '{VEC_EXT, VEC_TMR1, VEC_TMR2, VEC_CONV, VEC_SER};

  vic_top dut (.REF_CLK_I(clk), .RESETN_I(rstn),
    .ENABLE_ALL_OP_I(ena), .DISABLE_ALL_OP_I(dis), .INSTR_DONE_I(done),
    .MULTI_CYCLE_I(multi), .SKIP_REQ_I(skreq), .SKIP_SEL_I(sksel), .SKIP_O(skip),
    .TAKE_O(take), .PUSH_RET_O(push), .CTX_SAVE_O(ctx), .VECTOR_O(vec),
    .GLOBAL_IRQ_ENABLE_O(gie), .EXT_PIN_I(pin), .TMR1_UFL_I(ev[0]),
    .TMR2_UFL_I(ev[1]), .CONV_DONE_I(ev[2]), .SERIAL_DONE_I(ev[3]),
    .AWADDR_I(awa), .AWVALID_I(awv), .AWREADY_O(awrdy), .WDATA_I(wd),
    .WSTRB_I(ws), .WVALID_I(wv), .WREADY_O(wrdy), .BRESP_O(bresp),
    .BVALID_O(bv), .BREADY_I(br), .ARADDR_I(ara), .ARVALID_I(arv),
    .ARREADY_O(arrdy), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rv),
    .RREADY_I(rr), .IRQ_O(irq));
  vic_partner sq (.clk_i(clk), .ena_o(ena), .dis_o(dis), .done_o(done),
    .multi_o(multi), .pin_o(pin), .ev_o(ev));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Address and data are offered together; each drops once taken.
  // Ready stays high between calls, so no signal is driven twice in a step.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awa <= a;
    wd  <= v;
    ws  <= 4'hF;
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (!bv);
    rsp = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arrdy) arv <= 1'b0;
    end while (!rv);
    d   = rdata;
    rsp = rresp;
  endtask : rd
  task automatic test_done();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // Free-running clock at 50 MHz.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Watchdog: the sequence needs well under ten thousand cycles.
  initial begin
    #200000;
    n_mismatch++;
    test_done();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rstn, skreq, awv, wv, br, arv, rr} = '0;
    sksel = 3'h0;
    awa = 8'h00;
    ara = 8'h00;
    wd = 32'h0000_0000;
    ws = 4'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    chk("vec_rst", vec, VEC_BASE);
    @(posedge clk);
    rd(OFS_REQ);
    chk("req_rst", d, 32'h0000_0000);
    wr(OFS_CTRL2, 32'h0000_000F);
    chk("wr_resp", rsp, RESP_OKAY);
    rd(OFS_CTRL2);
    chk("ctrl2", d, 32'h0000_000F);
    chk("rd_resp", rsp, RESP_OKAY);
    rd(8'h18);
    chk("bad_resp", rsp, RESP_SLVERR);
    chk("bad_data", d, 32'h0000_0000);
    // A misaligned write is refused and leaves the registers alone.
    wr(8'h06, 32'h0000_0000);
    chk("bad_wresp", rsp, RESP_SLVERR);
    rd(OFS_CTRL2);
    chk("ctrl2_kept", d, 32'h0000_000F);
    wr(OFS_CTRL2, 32'h0000_0000);
    // Events while everything is masked still latch.
    sq.fire(5'h1F);
    rd(OFS_REQ);
    chk("req_masked", d, 32'h0000_001F);
    // Masked sources skip and clear; selects above four never skip.
    skreq <= 1'b1;
    for (int s = 0; s < 6; s++) begin
      sksel <= s[2:0];
      #1;
      chk("skip", skip, s < 5);
      @(posedge clk);
    end
    skreq <= 1'b0;
    rd(OFS_REQ);
    chk("req_skipped", d, 32'h0000_0000);
    wr(OFS_CTRL1, 32'h0000_000D);
    wr(OFS_CTRL2, 32'h0000_000C);
    sq.fire(5'h1F);
    skreq <= 1'b1;
    for (int s = 0; s < 5; s++) begin
      sksel <= s[2:0];
      #1;
      chk("no_skip", skip, 0);
      @(posedge clk);
    end
    skreq <= 1'b0;
    rd(OFS_REQ);
    chk("req_held", d, 32'h0000_001F);
    // All five pending: each enable-all serves the next in priority.
    for (int k = 0; k < 5; k++) begin
      sq.op(1'b1, 1'b0);
      @(posedge clk);
      #1;
      chk("gie_wait", gie, 0);
      @(posedge clk);
      sq.retire(k, k == 1);
      #1;
      chk("gie_on", gie, 1);
      n = 0;
      while (take !== 1'b1 && n < 9) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk("latency", n, (k == 1) ? 3 : 2);
      chk("vector", vec, VEC_BASE + vt[k]);
      chk("entry", {push, ctx, gie}, 3'b110);
      @(posedge clk);
      rd(OFS_REQ);
      chk("req_left", d, (32'h1F << (k + 1)) & 32'h1F);
    end
    // After a take, a new request waits for enable-all.
    sq.fire(5'h01);
    repeat (4) @(posedge clk);
    rd(OFS_REQ);
    chk("req_blocked", d, 32'h0000_0001);
    // Disable lands before the take, so the request survives.
    sq.op(1'b1, 1'b0);
    sq.retire(0, 1'b0);
    sq.op(1'b0, 1'b1);
    #1;
    chk("gie_off", gie, 0);
    @(posedge clk);
    rd(OFS_REQ);
    chk("req_kept", d, 32'h0000_0001);
    rd(OFS_EVS);
    chk("status", d, 32'h0000_001F);
    wr(OFS_MASK, 32'h0000_0004);
    #1;
    chk("irq_on", irq, 1);
    @(posedge clk);
    wr(OFS_EVS, 32'h0000_0004);
    #1;
    chk("irq_off", irq, 0);
    @(posedge clk);
    rd(OFS_EVS);
    chk("status_w1c", d, 32'h0000_001B);
    test_done();
  end
endmodule : vic_top_test
`default_nettype wire
